// file: hdl/spc_defines.svh
// Contract
// [R1] Bit 7 set lets the host read and write the firmware SRAM over the serial port; clear blocks that access.
// [R2] Bit 6 set holds the internal processor in reset; clear lets it run.
// [R3] Setting or toggling bit 6 resets only the processor and leaves every host-visible register unchanged.
// [R4] Bit 4 set turns on the SRAM parity check; clear turns it off.
// [R5] The host should turn the parity check on whenever the firmware SRAM is in use.
// [R6] Bit 3 set makes the processor run from SRAM and ROM; clear makes it run from ROM alone.
// [R7] After loading the SRAM the host must set bit 3 so the loaded code is used.
// [R8] All eight bits reset to zero, and bit 5 is plain read/write storage with no effect.
// [R9] Bits 2, 1 and 0 are plain read/write storage that resets to zero.
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

`define SPC_CMD_SRAM_CTRL   8'h60
`define SPC_CTRL_RESET      8'h00
`define SPC_DEV_ADDR        7'h20
`define SPC_BIT_HOST_PROGRAM_SELECT    7
`define SPC_BIT_CPU_RST     6
`define SPC_BIT_PARITY_CHECK_ENABLE      4
`define SPC_BIT_RAM_EN      3
`define SPC_BIT_PARITY_SELECT     2
`define SPC_BIT_DIR         1
`define SPC_BIT_PTR_CLR     0
`define SPC_BITS_PER_BYTE   4'h8
`define SPC_LAST_BIT        4'h7

`endif

// file: hdl/spc_pkg.sv
package spc_pkg;
  typedef enum logic [3:0] {
    SPC_IDLE,
    SPC_ADDR,
    SPC_ADDR_ACK,
    SPC_CMD,
    SPC_CMD_ACK,
    SPC_WDATA,
    SPC_WDATA_ACK,
    SPC_RDATA,
    SPC_RDATA_ACK
  } spc_state_t;
endpackage

// file: hdl/spc_sync.sv
module spc_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst_b,  // Async reset, active low
  input  wire logic [W-1:0] d,      // Asynchronous pins
  output logic      [W-1:0] q       // Synchronised copy
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Reset high: an idle open-drain bus floats high
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// file: hdl/spc_ctrl.sv
`include "spc_defines.svh"

module spc_ctrl #(
  parameter logic [6:0] DEV_ADDR = `SPC_DEV_ADDR  // Bus address, value arbitrary
) (
  input  wire logic clk,                  // System clock, 10 MHz
  input  wire logic rst_b,                // Async reset, active low
  input  wire logic scl_in,               // Serial clock pin
  input  wire logic sda_in,               // Serial data pin level
  output logic      sda_out,              // Serial data drive value, always low
  output logic      sda_oe_b,             // Serial data enable, low drives low
  output logic      host_program_select,  // Host SRAM access allowed
  output logic      cpu_reset,            // Processor held in reset
  output logic      parity_check_enable,  // SRAM parity check on
  output logic      sram_exec_enable,     // Run from SRAM plus ROM
  output logic      parity_select,        // Stored, no function here
  output logic      access_direction,     // Stored, no function here
  output logic      pointer_clear         // Stored, no function here
);
  spc_pkg::spc_state_t state_q, state_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] sr_q, sr_d;
  logic [7:0] ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic       rw_q, rw_d;
  logic       ack_q, ack_d;
  logic       oe_b_q, oe_b_d;
  logic       scl_p_q, sda_p_q;
  logic       scl_s, sda_s;
  logic       scl_rise, scl_fall, start_c, stop_c;
  logic       wr_en;

  // Only the control command maps; other commands read zero
  function automatic logic [7:0] read_byte(input logic [7:0] ptr, input logic [7:0] ctrl);
    read_byte = (ptr == `SPC_CMD_SRAM_CTRL) ? ctrl : 8'h00;
  endfunction

  spc_sync #(.W(2)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({scl_in, sda_in}),
    .q     ({scl_s, sda_s})
  );

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;

  always_comb
  begin
    logic [7:0] rd;
    logic [7:0] nptr;
    rd      = 8'h00;
    nptr    = ptr_q + 8'h01;
    state_d = state_q;
    ctrl_d  = ctrl_q;
    sr_d    = sr_q;
    ptr_d   = ptr_q;
    cnt_d   = cnt_q;
    rw_d    = rw_q;
    ack_d   = ack_q;
    oe_b_d  = oe_b_q;
    wr_en   = 1'b0;
    if (stop_c)
    begin
      state_d = spc_pkg::SPC_IDLE;
      oe_b_d  = 1'b1;
    end
    else if (start_c)
    begin
      state_d = spc_pkg::SPC_ADDR;
      cnt_d   = 4'h0;
      oe_b_d  = 1'b1;
    end
    else
    begin
      unique case (state_q)
        spc_pkg::SPC_IDLE:
        begin
        end
        spc_pkg::SPC_ADDR, spc_pkg::SPC_CMD, spc_pkg::SPC_WDATA:
        begin
          if (scl_rise && cnt_q != `SPC_BITS_PER_BYTE)
          begin
            sr_d  = {sr_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == `SPC_BITS_PER_BYTE)
          begin
            cnt_d = 4'h0;
            if (state_q == spc_pkg::SPC_ADDR)
            begin
              if (sr_q[7:1] == DEV_ADDR)
              begin
                rw_d    = sr_q[0];
                state_d = spc_pkg::SPC_ADDR_ACK;
                oe_b_d  = 1'b0;
              end
              else
              begin
                state_d = spc_pkg::SPC_IDLE;
              end
            end
            else if (state_q == spc_pkg::SPC_CMD)
            begin
              ptr_d   = sr_q;
              state_d = spc_pkg::SPC_CMD_ACK;
              oe_b_d  = 1'b0;
            end
            else
            begin
              // Full byte in hand: commit only to the control command
              wr_en   = (ptr_q == `SPC_CMD_SRAM_CTRL);
              ptr_d   = nptr;
              state_d = spc_pkg::SPC_WDATA_ACK;
              oe_b_d  = 1'b0;
            end
          end
        end
        spc_pkg::SPC_ADDR_ACK, spc_pkg::SPC_CMD_ACK, spc_pkg::SPC_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            if (state_q == spc_pkg::SPC_ADDR_ACK && rw_q)
            begin
              rd      = read_byte(ptr_q, ctrl_q);
              sr_d    = rd;
              oe_b_d  = rd[7];
              state_d = spc_pkg::SPC_RDATA;
            end
            else
            begin
              oe_b_d  = 1'b1;
              state_d = (state_q == spc_pkg::SPC_ADDR_ACK) ? spc_pkg::SPC_CMD : spc_pkg::SPC_WDATA;
            end
          end
        end
        spc_pkg::SPC_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_q == `SPC_LAST_BIT)
            begin
              cnt_d   = 4'h0;
              oe_b_d  = 1'b1;
              state_d = spc_pkg::SPC_RDATA_ACK;
            end
            else
            begin
              cnt_d  = cnt_q + 4'h1;
              sr_d   = {sr_q[6:0], 1'b0};
              oe_b_d = sr_q[6];
            end
          end
        end
        spc_pkg::SPC_RDATA_ACK:
        begin
          if (scl_rise)
          begin
            ack_d = ~sda_s;
          end
          else if (scl_fall)
          begin
            if (ack_q)
            begin
              rd      = read_byte(nptr, ctrl_q);
              ptr_d   = nptr;
              sr_d    = rd;
              oe_b_d  = rd[7];
              state_d = spc_pkg::SPC_RDATA;
            end
            else
            begin
              state_d = spc_pkg::SPC_IDLE;
            end
          end
        end
      endcase
    end
    // Whole byte stored, reserved and undefined bits too
    if (wr_en)
    begin
      ctrl_d = sr_q;  // [R8] [R9]
    end
  end

  // Only rst_b clears the register; the processor reset bit never does
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= spc_pkg::SPC_IDLE;
      ctrl_q  <= `SPC_CTRL_RESET;  // [R8] [R3]
      sr_q    <= 8'h00;
      ptr_q   <= 8'h00;
      cnt_q   <= 4'h0;
      rw_q    <= 1'b0;
      ack_q   <= 1'b0;
      oe_b_q  <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      ctrl_q  <= ctrl_d;
      sr_q    <= sr_d;
      ptr_q   <= ptr_d;
      cnt_q   <= cnt_d;
      rw_q    <= rw_d;
      ack_q   <= ack_d;
      oe_b_q  <= oe_b_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign sda_out             = 1'b0;
  assign sda_oe_b            = oe_b_q;
  assign host_program_select = ctrl_q[`SPC_BIT_HOST_PROGRAM_SELECT];  // [R1]
  assign cpu_reset           = ctrl_q[`SPC_BIT_CPU_RST];   // [R2]
  assign parity_check_enable = ctrl_q[`SPC_BIT_PARITY_CHECK_ENABLE];    // [R4]
  assign sram_exec_enable    = ctrl_q[`SPC_BIT_RAM_EN];    // [R6]
  assign parity_select       = ctrl_q[`SPC_BIT_PARITY_SELECT];   // [R9]
  assign access_direction    = ctrl_q[`SPC_BIT_DIR];       // [R9]
  assign pointer_clear       = ctrl_q[`SPC_BIT_PTR_CLR];   // [R9]

  logic seen_wr_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seen_wr_q <= 1'b0;
    end
    else
    begin
      seen_wr_q <= seen_wr_q | wr_en;
    end
  end

  chk_host_program_select_write: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
    wr_en |=> host_program_select == $past(sr_q[7]))
    else $error("program select did not follow write");
  chk_cpu_rst_write: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
    wr_en |=> cpu_reset == $past(sr_q[6]))
    else $error("processor reset did not follow write");
  chk_regs_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
    (!wr_en && cpu_reset) |=> $stable(ctrl_q))
    else $error("register changed without a write");
  chk_parity_write: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
    wr_en |=> parity_check_enable == $past(sr_q[4]))
    else $error("parity enable did not follow write");
  chk_exec_write: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
    wr_en |=> sram_exec_enable == $past(sr_q[3]))
    else $error("execution select did not follow write");
  chk_reset_zero: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
    !seen_wr_q |-> ctrl_q == 8'h00)
    else $error("control register not zero before first write");
  chk_low_bits_write: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
    wr_en |=> {ctrl_q[5], parity_select, access_direction, pointer_clear} == $past({sr_q[5], sr_q[2:0]}))
    else $error("stored bits did not follow write");
  chk_ack_drive: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
    (state_q == spc_pkg::SPC_CMD_ACK) |-> !sda_oe_b)
    else $error("command byte not acknowledged");
endmodule

// file: tb/spc_host.sv
`include "spc_defines.svh"

module spc_host (
  input  wire logic clk,       // System clock
  input  wire logic sda,       // Wired data level
  output logic      scl,       // Serial clock drive
  output logic      sda_drv_b  // Data drive, low pulls low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl = 1'b1;
    sda_drv_b = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves 6 clk after the clock fall, so the device's hold and release fit
  task automatic xfer9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_drv_b = tx[i];
      tick(6);
      scl = 1'b1;
      tick(4);
      rx[i] = sda;
      tick(4);
      scl = 1'b0;
      tick(6);
    end
  endtask
  task automatic start();
    sda_drv_b = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(8);
    sda_drv_b = 1'b0;
    tick(8);
    scl = 1'b0;
    tick(6);
  endtask
  task automatic stop();
    sda_drv_b = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(8);
    sda_drv_b = 1'b1;
    tick(8);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic [2:0] acks);
    logic [8:0] r;
    start();
    xfer9({a, 1'b0, 1'b1}, r);
    acks[2] = r[0];
    xfer9({c, 1'b1}, r);
    acks[1] = r[0];
    xfer9({d, 1'b1}, r);
    acks[0] = r[0];
    stop();
  endtask
  // Two data bytes in one write, pointer steps between them
  task automatic wr2(input logic [7:0] c, input logic [15:0] d, output logic [3:0] acks);
    logic [8:0] r;
    start();
    xfer9({`SPC_DEV_ADDR, 1'b0, 1'b1}, r);
    acks[3] = r[0];
    xfer9({c, 1'b1}, r);
    acks[2] = r[0];
    xfer9({d[15:8], 1'b1}, r);
    acks[1] = r[0];
    xfer9({d[7:0], 1'b1}, r);
    acks[0] = r[0];
    stop();
  endtask
  // Master ACKs the first byte so the device sends the next one
  task automatic rd2(input logic [7:0] c, output logic [15:0] d);
    logic [8:0] r;
    start();
    xfer9({`SPC_DEV_ADDR, 1'b0, 1'b1}, r);
    xfer9({c, 1'b1}, r);
    start();
    xfer9({`SPC_DEV_ADDR, 1'b1, 1'b1}, r);
    xfer9({8'hff, 1'b0}, r);
    d[15:8] = r[8:1];
    xfer9({8'hff, 1'b1}, r);
    d[7:0] = r[8:1];
    stop();
  endtask
  // Single byte read ends with a master NACK
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    logic [8:0] r;
    start();
    xfer9({`SPC_DEV_ADDR, 1'b0, 1'b1}, r);
    xfer9({c, 1'b1}, r);
    start();
    xfer9({`SPC_DEV_ADDR, 1'b1, 1'b1}, r);
    xfer9({8'hff, 1'b1}, r);
    d = r[8:1];
    stop();
  endtask
endmodule

// file: tb/testbench.sv
`include "spc_defines.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       rst_b;
  logic       scl;
  logic       host_drv_b;
  logic       sda_out;
  logic       sda_oe_b;
  wire  logic [7:0] outs;
  logic [7:0] rd_v;
  logic [2:0] acks;
  wire  logic sda;
  int         n_fail = 0;
  int         total_checks = 0;
  // Pull-up: line is low only when somebody drives it
  assign sda = host_drv_b & (sda_oe_b ? 1'b1 : sda_out);
  spc_host host_i (.clk(clk), .sda(sda), .scl(scl), .sda_drv_b(host_drv_b));
  spc_ctrl spc_ctrl_i (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_b(sda_oe_b), .host_program_select(outs[7]), .cpu_reset(outs[6]), .parity_check_enable(outs[4]),
    .sram_exec_enable(outs[3]), .parity_select(outs[2]), .access_direction(outs[1]), .pointer_clear(outs[0]));
  assign outs[5] = 1'b0;
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic put(input logic [7:0] v);
    host_i.wr(`SPC_DEV_ADDR, `SPC_CMD_SRAM_CTRL, v, acks);
    `CHK("write acks", 3'b000, acks)
  endtask
  task automatic expect_reg(input logic [7:0] v);
    host_i.rd(`SPC_CMD_SRAM_CTRL, rd_v);
    `CHK("readback", v, rd_v)
    `CHK("outputs", v & 8'hdf, outs)
  endtask
  task automatic t_reset();
    rst_b = 1'b0;
    host_i.tick(20);
    rst_b = 1'b1;
    host_i.tick(4);
    `CHK("sda_oe_b", 1'b1, sda_oe_b)
    `CHK("reset outputs", 8'h00, outs)
    expect_reg(8'h00);
  endtask
  task automatic t_bits();
    for (int i = 0; i < 8; i++)
    begin
      put(8'h01 << i);
      expect_reg(8'h01 << i);
    end
    put(8'hff);
    expect_reg(8'hff);
  endtask
  // With program select, parity and SRAM execution set, bit 6 holds and then releases the processor
  task automatic t_cpu_rst();
    put(8'h98);
    put(8'hd8);
    expect_reg(8'hd8);
    put(8'h98);
    expect_reg(8'h98);
  endtask
  task automatic t_refuse();
    host_i.wr(`SPC_DEV_ADDR ^ 7'h01, `SPC_CMD_SRAM_CTRL, 8'h00, acks);
    `CHK("foreign acks", 3'b111, acks)
    host_i.wr(`SPC_DEV_ADDR, 8'h61, 8'hff, acks);
    host_i.rd(8'h61, rd_v);
    `CHK("other command", 8'h00, rd_v)
    expect_reg(8'h98);
  endtask
  // Pointer steps from the byte before onto the control command, on write and on read
  task automatic t_auto_inc();
    logic [15:0] two;
    logic [3:0]  acks4;
    host_i.wr2(`SPC_CMD_SRAM_CTRL - 8'h01, 16'h5ac8, acks4);
    `CHK("burst acks", 4'h0, acks4)
    host_i.rd2(`SPC_CMD_SRAM_CTRL - 8'h01, two);
    `CHK("burst read", 16'h00c8, two)
    `CHK("burst outputs", 8'hc8, outs)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    rst_b = 1'b0;
    t_reset();
    t_bits();
    t_cpu_rst();
    t_refuse();
    t_auto_inc();
    t_reset();
    end_of_test();
  end
  initial
  begin
    #6_000_000;
    n_fail++;
    end_of_test();
  end
endmodule
